// *** src/cimc_top.sv ***
// Function
// RULE1: a zero mask bit compares that identifier bit; a one excludes it.
// RULE2: every mask spans the full 29-bit identifier width.
// RULE3: for standard frames only mask bits 28..18 apply; 17..0 ignored.
// RULE4: rx active sets on received start-of-frame or on arbitration loss.
// RULE5: rx active clears on recessive second gap bit or init at first.
// RULE6: tx active sets on sent start-of-frame or first error-flag bit; the code takes the error flag only while tx active is already set.
// RULE7: tx active clears on bus-off, arbitration loss, gap bit two, init.
// RULE8: error-clear bit clears counters and info, then clears itself.
// RULE9: error-clear sets only in init, even when leaving; frozen in sleep/stop.
// RULE10: arbitration-loss retry bit enables retransmit only in single-shot.
// RULE11: valid flag sets on any valid received frame since last clear.
// RULE12: software clears valid before leaving init and reads it back.
// RULE13: receive-only mode drives no acknowledge.
// RULE14: power-save 00 none, 01 sleep, 11 stop; 10 prohibited.
// RULE15: stop is entered or left only through sleep.
// RULE16: sleep request pends until cancelled or bus idle; field shows state.
// RULE17: software checks buffer access flag after leaving power save.
// RULE18: op field 000 init to 101 self-test; 110 and 111 prohibited.
// RULE19: software reads back mode fields to confirm a change.
// RULE20: op field is read-only in sleep or stop.
// RULE21: control writes use bits 15..8 as set, 7..0 as clear.
// RULE22: set one clear zero sets, reverse clears, else unchanged.
// RULE23: error-clear becomes one only when set and clear both written one.
// RULE24: identifier matches when every unmasked bit equals the buffer bit.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cimc_top (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    // ahb-lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // protocol engine events, same clock
    input  wire logic        i_rx_sof,
    input  wire logic        i_tx_sof,
    input  wire logic        i_arb_lost,
    input  wire logic        i_err_flag_first,
    input  wire logic        i_bus_off_enter,
    input  wire logic        i_ifs_first_bit,
    input  wire logic        i_ifs_second_recessive,
    input  wire logic        i_valid_frame,
    input  wire logic        i_bus_idle,
    // acceptance filter
    input  wire logic [28:0] i_rx_id,
    input  wire logic        i_rx_extended,
    input  wire logic [28:0] i_buf_id,
    input  wire logic [2:0]  i_mask_sel,
    output logic             o_id_match,
    // mode outputs
    output logic      [2:0]  o_operating_select,
    output logic      [1:0]  o_power_save_select,
    output logic             o_ack_enable,
    output logic             o_retx_on_arb_loss,
    output logic             o_err_count_clear,
    output logic             o_rx_active_flag,
    output logic             o_tx_active_flag
);
    import cimc_pkg::*;

    cimc_bus_e   bus_state;
    logic [15:0] wr_index;
    logic        wr_map_hi;
    logic [15:0] mask_low  [NUM_MASKS];
    logic [12:0] mask_high [NUM_MASKS];
    logic [2:0]  op_mode;
    logic [1:0]  ps_mode;
    logic        sleep_pend;
    logic        err_clr;
    logic        arb_retry;
    logic        valid_flag;
    logic        rx_act;
    logic        tx_act;

    logic        addr_ok;
    logic        ctrl_wr;
    logic [7:0]  wr_set;
    logic [7:0]  wr_clr;
    logic [2:0]  next_op;
    logic [1:0]  ps_req;
    logic [31:0] next_rdata;

    // set/clear pair: set-only sets, clear-only clears, else hold
    function automatic logic pair_upd(input logic cur, input logic s,
                                      input logic c);
        pair_upd = (s & ~c) ? 1'b1 : ((~s & c) ? 1'b0 : cur); // RULE22
    endfunction

    function automatic logic [28:0] mask_of(input logic [2:0] sel,
                                            input logic [15:0] lo [NUM_MASKS],
                                            input logic [12:0] hi [NUM_MASKS]);
        mask_of = '0;
        for (int k = 0; k < NUM_MASKS; k++) begin
            if (sel == 3'(k + 1)) begin
                mask_of = {hi[k], lo[k]}; // RULE2
            end
        end
    endfunction

    function automatic logic id_match(input logic [28:0] rx,
                                      input logic [28:0] bid,
                                      input logic [28:0] msk,
                                      input logic ext);
        logic [28:0] care;
        care = ~msk; // RULE1
        if (!ext) begin
            care[STD_LOW_BITS-1:0] = '0; // RULE3
        end
        id_match = ((rx ^ bid) & care) == '0; // RULE24
    endfunction

    function automatic logic [15:0] reg_read(input logic [15:0] idx,
                                             input logic [15:0] lo [NUM_MASKS],
                                             input logic [12:0] hi [NUM_MASKS],
                                             input logic [15:0] ctrl);
        reg_read = '0;
        for (int k = 0; k < NUM_MASKS; k++) begin
            if (idx == IDX_MASK1_LOW + 16'(4 * k)) begin
                reg_read = lo[k];
            end
            if (idx == IDX_MASK1_HIGH + 16'(4 * k)) begin
                reg_read = {3'h0, hi[k]};
            end
        end
        if (idx == IDX_MODE_CTRL) begin
            reg_read = ctrl;
        end
    endfunction

    // bus address phase decode
    always_comb begin
        addr_ok = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
    end

    // bus phase tracking; reads take one wait state
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus_state   <= BUS_IDLE;
            wr_index    <= 16'h0000;
            wr_map_hi   <= 1'b0;
            o_hreadyout <= 1'b1;
        end else begin
            case (bus_state)
                BUS_RD: begin
                    bus_state   <= BUS_IDLE;
                    o_hreadyout <= 1'b1;
                end
                BUS_IDLE, BUS_WR: begin
                    if (addr_ok) begin
                        wr_index  <= i_haddr[17:2];
                        wr_map_hi <= (i_haddr[31:18] != 14'h0000);
                        if (i_hwrite) begin
                            bus_state <= BUS_WR;
                        end else begin
                            bus_state   <= BUS_RD;
                            o_hreadyout <= 1'b0;
                        end
                    end else begin
                        bus_state <= BUS_IDLE;
                    end
                end
                default: begin
                    bus_state   <= BUS_IDLE;
                    o_hreadyout <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_hresp <= 1'b0;
        end else begin
            o_hresp <= 1'b0;
        end
    end

    // read data, sampled in the wait cycle after any earlier write landed
    always_comb begin
        next_rdata = '0;
        if (!wr_map_hi) begin
            next_rdata[15:0] = reg_read(wr_index, mask_low, mask_high,
                {6'h00, rx_act, tx_act, err_clr, arb_retry, valid_flag,
                 ps_mode, op_mode});
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_hrdata <= 32'h0000_0000;
        end else if (bus_state == BUS_RD) begin
            o_hrdata <= next_rdata;
        end
    end

    // mask registers
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int k = 0; k < NUM_MASKS; k++) begin
                mask_low[k]  <= MASK_RESET;
                mask_high[k] <= MASK_RESET[MASK_HIGH_W-1:0];
            end
        end else if (bus_state == BUS_WR && !wr_map_hi) begin
            for (int k = 0; k < NUM_MASKS; k++) begin
                if (wr_index == IDX_MASK1_LOW + 16'(4 * k)) begin
                    mask_low[k] <= i_hwdata[15:0];
                end
                if (wr_index == IDX_MASK1_HIGH + 16'(4 * k)) begin
                    mask_high[k] <= i_hwdata[MASK_HIGH_W-1:0]; // RULE2
                end
            end
        end
    end

    // control write split into set and clear halves
    always_comb begin
        ctrl_wr = (bus_state == BUS_WR) && !wr_map_hi
                  && (wr_index == IDX_MODE_CTRL);
        wr_set  = ctrl_wr ? i_hwdata[15:8] : 8'h00; // RULE21
        wr_clr  = ctrl_wr ? i_hwdata[7:0] : 8'h00; // RULE21
        for (int b = 0; b < 3; b++) begin
            next_op[b] = pair_upd(op_mode[b], wr_set[CTRL_OP_LSB + b],
                                  wr_clr[CTRL_OP_LSB + b]);
        end
        for (int b = 0; b < 2; b++) begin
            ps_req[b] = pair_upd(ps_mode[b], wr_set[CTRL_PS_LSB + b],
                                 wr_clr[CTRL_PS_LSB + b]);
        end
    end

    // operating mode
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            op_mode <= CTRL_RESET[2:0];
        end else if (ctrl_wr && ps_mode == PS_NONE // RULE20
                     && next_op <= OP_SELFTEST) begin // RULE18
            op_mode <= next_op;
        end
    end

    // power save: actual state plus pending sleep request
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ps_mode    <= CTRL_RESET[4:3];
            sleep_pend <= 1'b0;
        end else begin
            if (ctrl_wr && (ps_req != ps_mode || wr_clr[CTRL_PS_LSB])) begin
                case (ps_req) // RULE14
                    PS_NONE: begin
                        sleep_pend <= 1'b0; // RULE16
                        if (ps_mode == PS_SLEEP) begin
                            ps_mode <= PS_NONE;
                        end
                    end
                    PS_SLEEP: begin
                        if (ps_mode == PS_STOP) begin
                            ps_mode <= PS_SLEEP; // RULE15
                        end else begin
                            sleep_pend <= 1'b1; // RULE16
                        end
                    end
                    PS_STOP: begin
                        if (ps_mode == PS_SLEEP) begin
                            ps_mode <= PS_STOP; // RULE15
                        end
                    end
                    default: begin
                        ps_mode <= ps_mode;
                    end
                endcase
            end else if (sleep_pend && i_bus_idle) begin
                ps_mode    <= PS_SLEEP; // RULE16
                sleep_pend <= 1'b0;
            end
        end
    end

    // error counter clear bit and its self-clearing pulse
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            err_clr           <= 1'b0;
            o_err_count_clear <= 1'b0;
        end else begin
            o_err_count_clear <= err_clr && !o_err_count_clear; // RULE8
            if (wr_set[7] && wr_clr[7] && op_mode == OP_INIT // RULE23
                && ps_mode == PS_NONE) begin // RULE9
                err_clr <= 1'b1;
            end else if (o_err_count_clear) begin
                err_clr <= 1'b0; // RULE8
            end
        end
    end

    // arbitration-loss retry and valid flag
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            arb_retry  <= 1'b0;
            valid_flag <= 1'b0;
        end else begin
            arb_retry <= pair_upd(arb_retry, wr_set[6], wr_clr[6]);
            if (i_valid_frame) begin
                valid_flag <= 1'b1; // RULE11
            end else if (wr_clr[CTRL_VALID]) begin
                valid_flag <= 1'b0;
            end
        end
    end

    // activity flags; a set event wins over a clear in the same cycle
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_act <= 1'b0;
            tx_act <= 1'b0;
        end else begin
            if (i_rx_sof || i_arb_lost) begin
                rx_act <= 1'b1; // RULE4
            end else if (i_ifs_second_recessive
                         || (i_ifs_first_bit && op_mode == OP_INIT)) begin
                rx_act <= 1'b0; // RULE5
            end
            if (i_tx_sof || (i_err_flag_first && tx_act)) begin
                tx_act <= 1'b1; // RULE6
            end else if (i_bus_off_enter || i_arb_lost
                         || i_ifs_second_recessive
                         || (i_ifs_first_bit && op_mode == OP_INIT)) begin
                tx_act <= 1'b0; // RULE7
            end
        end
    end

    // registered mode and filter outputs
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_id_match          <= 1'b0;
            o_operating_select  <= CTRL_RESET[2:0];
            o_power_save_select <= CTRL_RESET[4:3];
            o_ack_enable        <= 1'b0;
            o_retx_on_arb_loss  <= 1'b0;
            o_rx_active_flag    <= 1'b0;
            o_tx_active_flag    <= 1'b0;
        end else begin
            o_id_match <= id_match(i_rx_id, i_buf_id,
                              mask_of(i_mask_sel, mask_low, mask_high),
                              i_rx_extended);
            o_operating_select  <= op_mode;
            o_power_save_select <= ps_mode;
            o_ack_enable        <= (op_mode != OP_INIT)
                                   && (op_mode != OP_RX_ONLY); // RULE13
            o_retx_on_arb_loss  <= (op_mode != OP_SINGLE)
                                   || arb_retry; // RULE10
            o_rx_active_flag    <= rx_act;
            o_tx_active_flag    <= tx_act;
        end
    end
endmodule // cimc_top
`default_nettype wire

// *** src/cimc_pkg.sv ***
package cimc_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_MASK1_LOW  = 16'hff70;
    localparam logic [15:0] IDX_MASK1_HIGH = 16'hff72;
    localparam logic [15:0] IDX_MASK2_LOW  = 16'hff74;
    localparam logic [15:0] IDX_MASK2_HIGH = 16'hff76;
    localparam logic [15:0] IDX_MASK3_LOW  = 16'hff78;
    localparam logic [15:0] IDX_MASK3_HIGH = 16'hff7a;
    localparam logic [15:0] IDX_MASK4_LOW  = 16'hff7c;
    localparam logic [15:0] IDX_MASK4_HIGH = 16'hff7e;
    localparam logic [15:0] IDX_MODE_CTRL  = 16'hff90;
    localparam int          NUM_MASKS      = 4;
    localparam int          ID_W           = 29;
    localparam int          STD_LOW_BITS   = 18;
    localparam int          MASK_HIGH_W    = 13;

    localparam logic [15:0] MASK_RESET     = 16'h0000;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;

    // control register field positions (read view)
    localparam int CTRL_RX_ACT  = 9;
    localparam int CTRL_TX_ACT  = 8;
    localparam int CTRL_ERRCLR  = 7;
    localparam int CTRL_ARBRTY  = 6;
    localparam int CTRL_VALID   = 5;
    localparam int CTRL_PS_LSB  = 3;
    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_SET_OFS = 8;

    localparam logic [2:0] OP_INIT     = 3'h0;
    localparam logic [2:0] OP_NORMAL   = 3'h1;
    localparam logic [2:0] OP_NORM_ABT = 3'h2;
    localparam logic [2:0] OP_RX_ONLY  = 3'h3;
    localparam logic [2:0] OP_SINGLE   = 3'h4;
    localparam logic [2:0] OP_SELFTEST = 3'h5;

    localparam logic [1:0] PS_NONE  = 2'h0;
    localparam logic [1:0] PS_SLEEP = 2'h1;
    localparam logic [1:0] PS_BAD   = 2'h2;
    localparam logic [1:0] PS_STOP  = 2'h3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WR   = 3'b010,
        BUS_RD   = 3'b100
    } cimc_bus_e;
endpackage

// *** sim/cimc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module cimc_checker
    import cimc_pkg::*;
(
    input wire logic       i_clk_sys,
    input wire logic       i_rst_b,
    input wire logic       i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic       i_hwrite,
    input wire logic       i_hready,
    input wire logic       o_hreadyout,
    input wire logic       o_hresp,
    input wire logic       i_rx_sof,
    input wire logic       i_tx_sof,
    input wire logic       i_arb_lost,
    input wire logic       i_err_flag_first,
    input wire logic       i_bus_off_enter,
    input wire logic       i_ifs_second_recessive,
    input wire logic [2:0] o_operating_select,
    input wire logic [1:0] o_power_save_select,
    input wire logic       o_ack_enable,
    input wire logic       o_retx_on_arb_loss,
    input wire logic       o_err_count_clear,
    input wire logic       o_rx_active_flag,
    input wire logic       o_tx_active_flag
);
    logic armed;
    // mode outputs are only meaningful once the first edge after reset ran
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) armed <= 1'b0;
        else armed <= 1'b1;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    property p_hresp; o_hresp == 1'b0; endproperty
    a_hresp: assert property (p_hresp) else $error("hresp not okay");
    property p_rd_wait;
        i_hsel && i_hready && i_htrans == HTRANS_NONSEQ && !i_hwrite
        |=> !o_hreadyout ##1 o_hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_rx_set; i_rx_sof || i_arb_lost |-> ##2 o_rx_active_flag;
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("rx flag not set");
    property p_rx_clr;
        i_ifs_second_recessive && !i_rx_sof && !i_arb_lost
        |-> ##2 !o_rx_active_flag;
    endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("rx flag kept");
    property p_tx_set; i_tx_sof |-> ##2 o_tx_active_flag; endproperty
    a_tx_set: assert property (p_tx_set) else $error("tx flag not set");
    property p_tx_clr;
        (i_arb_lost || i_bus_off_enter) && !i_tx_sof && !i_err_flag_first
        |-> ##2 !o_tx_active_flag;
    endproperty
    a_tx_clr: assert property (p_tx_clr) else $error("tx flag kept");
    property p_ps_legal; o_power_save_select != PS_BAD; endproperty
    a_ps_legal: assert property (p_ps_legal) else $error("ps 10");
    property p_stop_path;
        $changed(o_power_save_select) && (o_power_save_select == PS_STOP
        || $past(o_power_save_select) == PS_STOP)
        |-> (o_power_save_select ^ $past(o_power_save_select)) == 2'h2;
    endproperty
    a_stop_path: assert property (p_stop_path) else $error("stop jump");
    property p_op_legal; o_operating_select <= OP_SELFTEST; endproperty
    a_op_legal: assert property (p_op_legal) else $error("op bad");
    property p_ack;
        armed |-> o_ack_enable == !(o_operating_select == OP_INIT
        || o_operating_select == OP_RX_ONLY);
    endproperty
    a_ack: assert property (p_ack) else $error("ack enable wrong");
    property p_retx;
        armed && o_operating_select != OP_SINGLE |-> o_retx_on_arb_loss;
    endproperty
    a_retx: assert property (p_retx) else $error("retx off");
    property p_clr_pulse; o_err_count_clear |=> !o_err_count_clear;
    endproperty
    a_clr_pulse: assert property (p_clr_pulse) else $error("clr long");
    c_rx: cover property (o_rx_active_flag && o_tx_active_flag == 1'b0);
    c_stop: cover property (o_power_save_select == PS_STOP);
    c_clr: cover property (o_err_count_clear);
endmodule // cimc_checker
bind cimc_top cimc_checker u_cimc_checker (.i_clk_sys, .i_rst_b, .i_hsel,
    .i_htrans, .i_hwrite, .i_hready, .o_hreadyout, .o_hresp, .i_rx_sof,
    .i_tx_sof, .i_arb_lost, .i_err_flag_first, .i_bus_off_enter,
    .i_ifs_second_recessive, .o_operating_select, .o_power_save_select,
    .o_ack_enable, .o_retx_on_arb_loss, .o_err_count_clear,
    .o_rx_active_flag, .o_tx_active_flag);
`default_nettype wire

// *** sim/cimc_can_node.sv ***
`timescale 1ns/1ps
`default_nettype none
// far-side nodes: kind 0 rx, 1 tx, 2 tx losing arbitration, 3 tx to bus-off
module cimc_can_node (
    input wire logic       i_clk_sys,
    input wire logic       i_start,
    input wire logic [1:0] i_kind,
    output logic           o_rx_sof = 1'b0,
    output logic           o_tx_sof = 1'b0,
    output logic           o_arb_lost = 1'b0,
    output logic           o_err_flag_first = 1'b0,
    output logic           o_bus_off_enter = 1'b0,
    output logic           o_ifs_first_bit = 1'b0,
    output logic           o_ifs_second_recessive = 1'b0,
    output logic           o_valid_frame = 1'b0,
    output logic           o_bus_idle = 1'b1
);
    always @(posedge i_clk_sys) begin
        if (i_start) begin
            o_bus_idle <= 1'b0;
            o_rx_sof <= (i_kind == 2'h0);
            o_tx_sof <= (i_kind != 2'h0);
            @(posedge i_clk_sys);
            o_rx_sof <= 1'b0;
            o_tx_sof <= 1'b0;
            repeat (7) @(posedge i_clk_sys);
            o_valid_frame <= (i_kind == 2'h0);
            o_arb_lost <= (i_kind == 2'h2);
            o_err_flag_first <= (i_kind == 2'h3);
            @(posedge i_clk_sys);
            o_valid_frame <= 1'b0;
            o_arb_lost <= 1'b0;
            o_err_flag_first <= 1'b0;
            o_bus_off_enter <= (i_kind == 2'h3);
            @(posedge i_clk_sys);
            o_bus_off_enter <= 1'b0;
            repeat (5) @(posedge i_clk_sys);
            o_ifs_first_bit <= 1'b1;
            @(posedge i_clk_sys);
            o_ifs_first_bit <= 1'b0;
            o_ifs_second_recessive <= 1'b1;
            @(posedge i_clk_sys);
            o_ifs_second_recessive <= 1'b0;
            o_bus_idle <= 1'b1;
        end
    end
endmodule // cimc_can_node
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cimc_pkg::*;
    logic        clk = 0, rst_b = 0, hsel = 0, hwrite = 0, st = 0, ext;
    logic [1:0]  htrans = 0, kind = 0;
    logic [31:0] haddr = 0, hwdata = 0, exp_q[$];
    logic [28:0] rx_id = 0, buf_id = 0, m, dif, mk[4];
    logic [2:0]  msel = 0;
    logic        dph = 0, rxs, txs, arb, efl, bof, if1, if2, vld, idle;
    wire  [31:0] hrdata;
    wire  [2:0]  opsel;
    wire  [1:0]  pssel;
    wire         hrdy, hresp, match, ack, retx, eclr, rxf, txf;
    int          err_count = 0, checks = 0, seed = 14217, ecnt = 0, s;
    always #2.5 clk = ~clk;
    cimc_top u_cimc_top (.i_clk_sys(clk), .i_rst_b(rst_b), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
        .o_hreadyout(hrdy), .o_hresp(hresp), .i_rx_sof(rxs), .i_tx_sof(txs),
        .i_arb_lost(arb), .i_err_flag_first(efl), .i_bus_off_enter(bof),
        .i_ifs_first_bit(if1), .i_ifs_second_recessive(if2),
        .i_valid_frame(vld), .i_bus_idle(idle), .i_rx_id(rx_id),
        .i_rx_extended(ext), .i_buf_id(buf_id), .i_mask_sel(msel),
        .o_id_match(match), .o_operating_select(opsel),
        .o_power_save_select(pssel), .o_ack_enable(ack),
        .o_retx_on_arb_loss(retx), .o_err_count_clear(eclr),
        .o_rx_active_flag(rxf), .o_tx_active_flag(txf));
    cimc_can_node u_cimc_can_node (.i_clk_sys(clk), .i_start(st),
        .i_kind(kind), .o_rx_sof(rxs), .o_tx_sof(txs), .o_arb_lost(arb),
        .o_err_flag_first(efl), .o_bus_off_enter(bof), .o_ifs_first_bit(if1),
        .o_ifs_second_recessive(if2), .o_valid_frame(vld), .o_bus_idle(idle));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task give_verdict();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // read results are compared in arrival order against the noted values
    always @(posedge clk) begin
        if (dph && hrdy === 1'b1) chk(hrdata, exp_q.pop_front());
        dph <= (dph && hrdy !== 1'b1) || (hsel && hrdy === 1'b1
            && htrans == HTRANS_NONSEQ && !hwrite);
        if (eclr === 1'b1) ecnt <= ecnt + 1;
    end
    task bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {14'h0, idx, 2'b00};
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
    endtask
    task wr(input logic [15:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    task rd(input logic [15:0] idx, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, idx, 32'h0);
    endtask
    task step(input logic [15:0] w, input logic [15:0] e);
        wr(IDX_MODE_CTRL, {16'h0, w});
        rd(IDX_MODE_CTRL, {16'h0, e});
        chk(opsel, e[2:0]);
        chk(pssel, e[4:3]);
        chk(ack, !(e[2:0] == OP_INIT || e[2:0] == OP_RX_ONLY));
        chk(retx, !(e[2:0] == OP_SINGLE && !e[6]));
    endtask
    task fr(input logic [1:0] k, input logic [15:0] a, b, c);
        st <= 1'b1;
        kind <= k;
        @(posedge clk);
        st <= 1'b0;
        repeat (2) @(posedge clk);
        rd(IDX_MODE_CTRL, {16'h0, a});
        repeat (6) @(posedge clk);
        rd(IDX_MODE_CTRL, {16'h0, b});
        repeat (12) @(posedge clk);
        rd(IDX_MODE_CTRL, {16'h0, c});
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    initial begin
        ext = 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd(IDX_MODE_CTRL, {16'h0, CTRL_RESET});
        rd(IDX_MASK1_LOW, {16'h0, MASK_RESET});
        wr(16'hff80, 32'h0000_1234);
        rd(16'hff80, 32'h0000_0000);
        for (int i = 0; i < NUM_MASKS; i++) begin
            mk[i] = 29'($random(seed));
            wr(IDX_MASK1_LOW + 16'(4 * i), {16'h0, mk[i][15:0]});
            wr(IDX_MASK1_HIGH + 16'(4 * i), {16'h0, 3'h7, mk[i][28:16]});
            rd(IDX_MASK1_LOW + 16'(4 * i), {16'h0, mk[i][15:0]});
            rd(IDX_MASK1_HIGH + 16'(4 * i), {19'h0, mk[i][28:16]});
        end
        for (int n = 0; n < 60; n++) begin
            m = 29'($random(seed));
            dif = 29'($random(seed) & $random(seed) & $random(seed));
            s = n % 5;
            ext <= n[1];
            rx_id <= m;
            buf_id <= m ^ dif;
            msel <= 3'(s);
            m = (s == 0) ? 29'h0 : mk[s - 1];
            if (!n[1]) m = m | 29'h3_ffff;
            @(posedge clk);
            @(posedge clk);
            chk(match, (dif & ~m) == 29'h0);
        end
        @(posedge clk);
        step(16'h4000, 16'h0040);
        step(16'h4040, 16'h0040);
        step(16'h0040, 16'h0000);
        step(16'h1800, 16'h0000);
        step(16'h1000, 16'h0000);
        step(16'h0106, 16'h0001);
        step(16'h0201, 16'h0002);
        step(16'h0100, 16'h0003);
        step(16'h0403, 16'h0004);
        step(16'h4000, 16'h0044);
        step(16'h0040, 16'h0004);
        step(16'h0100, 16'h0005);
        step(16'h0201, 16'h0005);
        step(16'h0007, 16'h0000);
        step(16'h8000, 16'h0000);
        step(16'h8080, 16'h0080);
        chk(ecnt, 1);
        st <= 1'b1;
        kind <= 2'h1;
        @(posedge clk);
        st <= 1'b0;
        step(16'h0800, 16'h0100);
        step(16'h0008, 16'h0100);
        repeat (30) @(posedge clk);
        rd(IDX_MODE_CTRL, 32'h0000_0000);
        step(16'h0800, 16'h0008);
        step(16'h0100, 16'h0008);
        step(16'h8080, 16'h0008);
        chk(ecnt, 1);
        step(16'h1000, 16'h0018);
        step(16'h0018, 16'h0018);
        step(16'h0010, 16'h0008);
        step(16'h0008, 16'h0000);
        step(16'h0106, 16'h0001);
        fr(2'h0, 16'h0201, 16'h0221, 16'h0021);
        step(16'h0020, 16'h0001);
        fr(2'h1, 16'h0101, 16'h0101, 16'h0001);
        fr(2'h2, 16'h0101, 16'h0201, 16'h0001);
        fr(2'h3, 16'h0101, 16'h0001, 16'h0001);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
